// File: verilog/aig_irq_gate.sv
`timescale 1ns/100ps
// Summary of operation
// [RULE_01] Four-bit index names highest pending auxiliary source.
// [RULE_02] All auxiliary sources share one vector address.
// [RULE_03] Index value serves directly as dispatch table index.
// [RULE_04] Mask write stores per-source enable, one enables.
// [RULE_05] Mask read returns raw unmasked source states.
// [RULE_06] Mask bit seven slow tick, zero core undervoltage.
// [RULE_07] Fixed priority: bit zero highest, bit seven lowest.
// [RULE_08] Serial receive and two-wire share one slot.
// [RULE_09] Undervoltage and breakpoint share top-priority slot.
// [RULE_10] Only control bit four enables auxiliary group.
// [RULE_11] Status bit is source active and enabled.
// [RULE_12] Global gate bit seven blocks all core sources.
// [RULE_13] Core mask bit layout: gate, uarts, timers, pins; code, bit 7 down: gate, uart1, timer2, uart0, timer1, pin b, timer0, pin a.
// [RULE_14] Serial enable passes receive or transmit flag.
// [RULE_15] Timer enables pass the timer overflow flags.
// [RULE_16] Pin enables pass external pin requests.
// [RULE_17] Index recomputed each clock, upper bits zero.
module aig_irq_gate
(
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Wishbone slave.
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [11:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // Auxiliary raw sources.
    input wire logic i_core_undervolt_or_break,
    input wire logic i_analog_undervolt,
    input wire logic i_serial_rx,
    input wire logic i_twowire_status,
    input wire logic i_serial_tx,
    input wire logic i_milli_tick,
    input wire logic i_conversion_done,
    input wire logic i_accumulator,
    input wire logic i_slow_tick,
    // Classic core sources.
    input wire logic i_uart0_rx_flag,
    input wire logic i_uart0_tx_flag,
    input wire logic i_uart1_rx_flag,
    input wire logic i_uart1_tx_flag,
    input wire logic i_timer0_overflow_flag,
    input wire logic i_timer1_overflow_flag,
    input wire logic i_timer2_overflow_flag,
    input wire logic i_ext_irq_pin_a,
    input wire logic i_ext_irq_pin_b,
    // Requests toward the core entry logic.
    output logic [6:0] o_core_irq_req,
    output logic o_aux_irq_req,
    output logic [15:0] o_aux_vector,
    output logic [3:0] o_aux_pending_index
);

    // ==========================================================
    // Registers and wires
    // ==========================================================
    logic [7:0] aux_mask_reg_ff;
    logic [7:0] core_irq_mask_ff;
    logic [7:0] ext_irq_ctrl_ff;
    logic [3:0] aux_pending_index_ff;
    logic [6:0] core_irq_req_ff;
    logic aux_irq_req_ff;
    logic [15:0] aux_vector_ff;
    logic wb_ack_ff;
    logic [31:0] wb_dat_ff;
    logic [7:0] aux_raw;
    logic [7:0] aux_flag;
    logic [6:0] core_src;
    logic [6:0] nxt_core_irq_req;
    logic [31:0] nxt_wb_dat;
    logic wb_req;
    logic wb_wr;
    logic [9:0] wb_word;
    logic global_irq_gate;
    logic aux_group_en;
    logic wr_aux_mask;
    logic wr_core_mask;
    logic wr_ext_ctrl;

    aig_prio_if prio ();

    // ==========================================================
    // Auxiliary source collection
    // ==========================================================
    // Shared slots are plain ORs; software tells the pair apart in the
    // owning peripheral, since one status bit cannot.
    // Sources are levels owned and cleared by their peripherals; no flag is
    // held here, so there is no set-against-clear race to resolve.
    always_comb
    begin
        aux_raw[0] = i_core_undervolt_or_break; // [RULE_09]
        aux_raw[1] = i_analog_undervolt; // [RULE_06]
        aux_raw[2] = i_serial_rx | i_twowire_status; // [RULE_08]
        aux_raw[3] = i_serial_tx;
        aux_raw[4] = i_milli_tick;
        aux_raw[5] = i_conversion_done;
        aux_raw[6] = i_accumulator;
        aux_raw[7] = i_slow_tick;
    end

    // Status is the source gated by its own mask only; the group enable does
    // not clear it, so software can poll with the group switched off.
    assign aux_flag = aux_raw & aux_mask_reg_ff; // [RULE_11]

    // The group enable sits in a register of its own, away from the core gate.
    assign aux_group_en = ext_irq_ctrl_ff[aig_pkg::AUX_GROUP_EN_BIT]; // [RULE_10]

    // ==========================================================
    // Priority encoder
    // ==========================================================
    // The encoder is combinational; its answer is registered below.
    assign prio.flags = aux_flag;

    aig_prio_enc aig_prio_enc_inst
    (
        .prio(prio)
    );

    // Index follows the live flags with one register stage. Software that
    // reads the index right after changing a mask may see the winner chosen
    // under the old mask for one cycle; a read requested straight after the
    // write's acknowledge, with no idle cycle, returns that old winner.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            aux_pending_index_ff <= aig_pkg::PENDING_NONE;
        end
        else
        begin
            aux_pending_index_ff <= prio.index; // [RULE_17] [RULE_07] [RULE_01]
        end
    end

    // Group request to the core; the core's own gate does not touch it.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            aux_irq_req_ff <= 1'b0;
        end
        else
        begin
            aux_irq_req_ff <= prio.any & aux_group_en; // [RULE_10]
        end
    end

    // Entry address presented with every auxiliary request. It is a constant,
    // but it is registered so that every output comes from a flip-flop.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            aux_vector_ff <= aig_pkg::AUX_VECTOR_ADDR;
        end
        else
        begin
            aux_vector_ff <= aig_pkg::AUX_VECTOR_ADDR; // [RULE_02]
        end
    end

    // ==========================================================
    // Classic core source gating
    // ==========================================================
    // Serial ports request on either completion flag. The flags are levels
    // held by their peripherals until software clears them, so no edge
    // capture is needed here.
    always_comb
    begin
        core_src[aig_pkg::EXT_PIN0_BIT] = i_ext_irq_pin_a; // [RULE_16]
        core_src[aig_pkg::TIMER0_BIT] = i_timer0_overflow_flag; // [RULE_15]
        core_src[aig_pkg::EXT_PIN1_BIT] = i_ext_irq_pin_b; // [RULE_16]
        core_src[aig_pkg::TIMER1_BIT] = i_timer1_overflow_flag; // [RULE_15]
        core_src[aig_pkg::UART0_BIT] = i_uart0_rx_flag | i_uart0_tx_flag; // [RULE_14]
        core_src[aig_pkg::TIMER2_BIT] = i_timer2_overflow_flag; // [RULE_15]
        core_src[aig_pkg::UART1_BIT] = i_uart1_rx_flag | i_uart1_tx_flag; // [RULE_14]
    end

    // The global gate covers the classic sources only.
    assign global_irq_gate = core_irq_mask_ff[aig_pkg::GLOBAL_IRQ_GATE_BIT];

    // Each request needs its own mask and the global gate.
    always_comb
    begin
        nxt_core_irq_req = {aig_pkg::NUM_CORE_SRC{global_irq_gate}} &
                           core_irq_mask_ff[6:0] & core_src; // [RULE_12] [RULE_13]
    end

    // Core requests change only on a clock edge, free of decode glitches.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            core_irq_req_ff <= 7'h00;
        end
        else
        begin
            core_irq_req_ff <= nxt_core_irq_req;
        end
    end

    // ==========================================================
    // Wishbone slave
    // ==========================================================
    // Register map: one byte-wide register per 32-bit word, at four times
    // its index. Only byte lane 0 carries data; the upper lanes read zero,
    // and a write with lane 0 disabled is dropped rather than half applied.
    // One wait state; ack drops the cycle after it rises so a held
    // request is never answered twice.
    assign wb_req = i_wb_cyc & i_wb_stb & ~wb_ack_ff;
    assign wb_word = i_wb_adr[11:2];

    // A write lands at the edge at which the master sees the acknowledge,
    // while its request still stands; landing it an edge earlier would
    // change a register before the bus cycle that asked for it had ended.
    assign wb_wr = i_wb_cyc & i_wb_stb & wb_ack_ff & i_wb_we & i_wb_sel[0];

    // Per-register write strobes, decoded from the word index.
    assign wr_aux_mask = wb_wr & (wb_word == {2'b00, aig_pkg::AUX_MASK_REG_IDX});
    assign wr_core_mask = wb_wr & (wb_word == {2'b00, aig_pkg::CORE_IRQ_MASK_IDX});
    assign wr_ext_ctrl = wb_wr & (wb_word == {2'b00, aig_pkg::EXT_IRQ_CTRL_IDX});

    // Every request is answered, mapped or not, so no master can hang.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            wb_ack_ff <= 1'b0;
        end
        else
        begin
            wb_ack_ff <= wb_req;
        end
    end

    // Auxiliary mask: writes store, reads do not return it.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            aux_mask_reg_ff <= aig_pkg::AUX_MASK_RST;
        end
        else if (wr_aux_mask)
        begin
            aux_mask_reg_ff <= i_wb_dat[7:0]; // [RULE_04]
        end
    end

    // Core mask register.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            core_irq_mask_ff <= aig_pkg::CORE_IRQ_MASK_RST;
        end
        else if (wr_core_mask)
        begin
            core_irq_mask_ff <= i_wb_dat[7:0]; // [RULE_13]
        end
    end

    // External-interrupt control; only the group enable bit acts here.
    // The other bits are stored only so that software reads back its value.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            ext_irq_ctrl_ff <= aig_pkg::EXT_IRQ_CTRL_RST;
        end
        else if (wr_ext_ctrl)
        begin
            ext_irq_ctrl_ff <= i_wb_dat[7:0];
        end
    end

    // Read mux; unmapped words read zero and still get an ack. Status and
    // raw sources are taken live, while the pending index is a cycle behind.
    always_comb
    begin
        nxt_wb_dat = 32'h0000_0000;
        unique case (wb_word)
            {2'b00, aig_pkg::AUX_PENDING_INDEX_IDX}:
            begin
                nxt_wb_dat[3:0] = aux_pending_index_ff; // [RULE_03] [RULE_17]
            end
            {2'b00, aig_pkg::AUX_MASK_REG_IDX}:
            begin
                nxt_wb_dat[7:0] = aux_raw; // [RULE_05]
            end
            {2'b00, aig_pkg::AUX_FLAG_REG_IDX}:
            begin
                nxt_wb_dat[7:0] = aux_flag; // [RULE_11]
            end
            {2'b00, aig_pkg::CORE_IRQ_MASK_IDX}:
            begin
                nxt_wb_dat[7:0] = core_irq_mask_ff;
            end
            {2'b00, aig_pkg::EXT_IRQ_CTRL_IDX}:
            begin
                nxt_wb_dat[7:0] = ext_irq_ctrl_ff;
            end
            default:
            begin
                nxt_wb_dat = 32'h0000_0000;
            end
        endcase
    end

    // Read data is captured with the ack and held until the next answer.
    // Writes leave it alone, so a master never mistakes it for fresh data.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            wb_dat_ff <= 32'h0000_0000;
        end
        else if (wb_req && !i_wb_we)
        begin
            wb_dat_ff <= nxt_wb_dat;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // Every output is a plain copy of a flip-flop.
    assign o_wb_dat = wb_dat_ff;
    assign o_wb_ack = wb_ack_ff;
    assign o_core_irq_req = core_irq_req_ff;
    assign o_aux_irq_req = aux_irq_req_ff;
    assign o_aux_vector = aux_vector_ff;
    assign o_aux_pending_index = aux_pending_index_ff;

endmodule

// File: verilog/aig_pkg.sv
package aig_pkg;

    // ==========================================================
    // Register indices and bus byte addresses
    // ==========================================================
    localparam logic [7:0] AUX_PENDING_INDEX_IDX = 8'hA5;
    localparam logic [7:0] AUX_MASK_REG_IDX = 8'hA6;
    localparam logic [7:0] AUX_FLAG_REG_IDX = 8'hA7;
    localparam logic [7:0] CORE_IRQ_MASK_IDX = 8'hA8;
    localparam logic [7:0] EXT_IRQ_CTRL_IDX = 8'hD8;
    localparam logic [9:0] AUX_PENDING_INDEX_ADR = {AUX_PENDING_INDEX_IDX, 2'b00};
    localparam logic [9:0] AUX_MASK_REG_ADR = {AUX_MASK_REG_IDX, 2'b00};
    localparam logic [9:0] AUX_FLAG_REG_ADR = {AUX_FLAG_REG_IDX, 2'b00};
    localparam logic [9:0] CORE_IRQ_MASK_ADR = {CORE_IRQ_MASK_IDX, 2'b00};
    localparam logic [9:0] EXT_IRQ_CTRL_ADR = {EXT_IRQ_CTRL_IDX, 2'b00};

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] AUX_MASK_RST = 8'h00;
    localparam logic [7:0] CORE_IRQ_MASK_RST = 8'h00;
    localparam logic [7:0] EXT_IRQ_CTRL_RST = 8'h00;
    localparam logic [3:0] PENDING_NONE = 4'h0;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int AUX_GROUP_EN_BIT = 4;
    localparam int GLOBAL_IRQ_GATE_BIT = 7;
    localparam int EXT_PIN0_BIT = 0;
    localparam int TIMER0_BIT = 1;
    localparam int EXT_PIN1_BIT = 2;
    localparam int TIMER1_BIT = 3;
    localparam int UART0_BIT = 4;
    localparam int TIMER2_BIT = 5;
    localparam int UART1_BIT = 6;
    localparam int NUM_CORE_SRC = 7;
    localparam int NUM_AUX_SRC = 8;

    // ==========================================================
    // Shared auxiliary entry address
    // ==========================================================
    localparam logic [15:0] AUX_VECTOR_ADDR = 16'h0033;

endpackage

// File: verilog/aig_prio_if.sv
`timescale 1ns/100ps
// Carries masked auxiliary flags to the priority encoder and its answer back.
interface aig_prio_if;
    logic [7:0] flags;
    logic [3:0] index;
    logic any;

    modport enc
    (
        input flags,
        output index,
        output any
    );

    modport ctl
    (
        output flags,
        input index,
        input any
    );
endinterface

// File: verilog/aig_prio_enc.sv
`timescale 1ns/100ps
// ==========================================================
// Fixed priority encoder: bit 0 highest, code is bit plus one
// ==========================================================
module aig_prio_enc
(
    // Flags in, index out.
    aig_prio_if.enc prio
);

    logic [7:0] first;
    logic [3:0] code [8];

    // Each flag wins only when no lower-numbered flag is set.
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_first
            if (g == 0)
            begin : g_top
                assign first[g] = prio.flags[g];
            end
            else
            begin : g_rest
                assign first[g] = prio.flags[g] & ~(|prio.flags[g-1:0]);
            end
            assign code[g] = first[g] ? 4'(g + 1) : 4'h0;
        end
    endgenerate

    // At most one code is non-zero, so OR-ing them yields the winner.
    always_comb
    begin
        prio.index = code[0] | code[1] | code[2] | code[3] |
                     code[4] | code[5] | code[6] | code[7];
        prio.any = |prio.flags;
    end

endmodule

// File: verif/aig_core_entry_model.sv
`timescale 1ns/100ps
// =====
// Stand-in for the processor's interrupt entry logic.
module aig_core_entry_model
(
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Requests from the gating block.
    input wire logic [6:0] i_core_irq_req,
    input wire logic i_aux_irq_req,
    input wire logic [15:0] i_aux_vector,
    // Shared entry address while an auxiliary request stands, zero otherwise.
    output logic [15:0] o_entry_addr
);
    // Every auxiliary source enters through the one shared vector, so no index is needed here.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            o_entry_addr <= 16'h0000;
        else
            o_entry_addr <= i_aux_irq_req ? i_aux_vector : 16'h0000;
    end
endmodule

// File: verif/aig_irq_gate_chk.sv
`timescale 1ns/100ps
// =====
// Port checker for the interrupt gating block.
module aig_irq_gate_chk
(
    // Clock, reset and bus.
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [11:0] i_wb_adr,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    // Auxiliary sources.
    input wire logic i_core_undervolt_or_break,
    input wire logic i_analog_undervolt,
    input wire logic i_serial_rx,
    input wire logic i_twowire_status,
    input wire logic i_serial_tx,
    input wire logic i_milli_tick,
    input wire logic i_conversion_done,
    input wire logic i_accumulator,
    input wire logic i_slow_tick,
    // Outputs toward the core.
    input wire logic o_aux_irq_req,
    input wire logic [15:0] o_aux_vector,
    input wire logic [3:0] o_aux_pending_index
);
    // Raw sources in register bit order; receive and two-wire share a slot.
    wire logic [7:0] raw_src = {i_slow_tick, i_accumulator, i_conversion_done, i_milli_tick,
        i_serial_tx, i_serial_rx | i_twowire_status, i_analog_undervolt, i_core_undervolt_or_break};
    wire logic take_rd = i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack;

    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    // Bus handshake, then the interrupt relations.
    a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("no acknowledge after a request");
    a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("acknowledge longer than one cycle");
    a_vector_fixed: assert property (o_aux_vector == aig_pkg::AUX_VECTOR_ADDR)
        else $error("shared vector changed");
    a_idx_none: assert property ($past(raw_src) == 8'h00 |-> o_aux_pending_index == 4'h0)
        else $error("index set with no source active");
    a_idx_live: assert property (o_aux_pending_index != 4'h0 |-> o_aux_pending_index <= 4'h8 &&
        ((($past(raw_src) >> (o_aux_pending_index - 4'h1)) & 8'h01) != 8'h00))
        else $error("index names an inactive source");
    a_aux_req_cause: assert property (o_aux_irq_req |-> $past(raw_src) != 8'h00)
        else $error("shared request without a source");
    a_mask_reads_raw: assert property (take_rd && i_wb_adr == {2'b00, aig_pkg::AUX_MASK_REG_ADR}
        |=> o_wb_dat == {24'h000000, $past(raw_src)})
        else $error("mask read did not return raw sources");
    a_flag_subset: assert property (take_rd && i_wb_adr == {2'b00, aig_pkg::AUX_FLAG_REG_ADR}
        |=> o_wb_dat[31:8] == 24'h000000 && (o_wb_dat[7:0] & ~$past(raw_src)) == 8'h00)
        else $error("status bit set for an inactive source");
    a_idx_upper_zero: assert property (take_rd && i_wb_adr == {2'b00, aig_pkg::AUX_PENDING_INDEX_ADR}
        |=> o_wb_dat[31:4] == 28'h0000000)
        else $error("index upper bits not zero");

    // Main scenarios reached.
    cover property (o_aux_irq_req);
    cover property (o_aux_pending_index == 4'h8);
    cover property (take_rd ##1 o_wb_ack);
endmodule

// File: verif/aig_irq_gate_tb_top.sv
`timescale 1ns/100ps
// =====
// Self-checking bench for the interrupt gating block.
module aig_irq_gate_tb_top;
    localparam logic [9:0] A_PEND = aig_pkg::AUX_PENDING_INDEX_ADR;
    localparam logic [9:0] A_MASK = aig_pkg::AUX_MASK_REG_ADR;
    localparam logic [9:0] A_FLAG = aig_pkg::AUX_FLAG_REG_ADR;
    localparam logic [9:0] A_CORE = aig_pkg::CORE_IRQ_MASK_ADR;
    localparam logic [9:0] A_EXT = aig_pkg::EXT_IRQ_CTRL_ADR;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_wb_cyc = 1'b0;
    logic i_wb_stb = 1'b0;
    logic i_wb_we = 1'b0;
    logic [11:0] i_wb_adr = 12'h000;
    logic [3:0] i_wb_sel = 4'h0;
    logic [31:0] i_wb_dat = 32'h00000000;
    logic [31:0] o_wb_dat, rdat;
    logic o_wb_ack, o_aux_irq_req;
    logic [6:0] o_core_irq_req;
    logic [15:0] o_aux_vector, entry;
    logic [3:0] o_aux_pending_index;
    logic [8:0] aux = 9'h000;
    logic [8:0] csrc = 9'h000;
    int n_mismatch = 0;
    int total_checks = 0;
    // Core mask bit that passes each classic source, in csrc order.
    int cbit [9] = '{0, 1, 2, 3, 4, 4, 5, 6, 6};

    aig_irq_gate aig_irq_gate_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
        .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
        .o_core_irq_req(o_core_irq_req), .o_aux_irq_req(o_aux_irq_req),
        .o_aux_vector(o_aux_vector), .o_aux_pending_index(o_aux_pending_index),
        .i_core_undervolt_or_break(aux[0]),
        .i_analog_undervolt(aux[1]), .i_serial_rx(aux[2]), .i_twowire_status(aux[3]),
        .i_serial_tx(aux[4]), .i_milli_tick(aux[5]), .i_conversion_done(aux[6]),
        .i_accumulator(aux[7]), .i_slow_tick(aux[8]), .i_ext_irq_pin_a(csrc[0]),
        .i_timer0_overflow_flag(csrc[1]), .i_ext_irq_pin_b(csrc[2]),
        .i_timer1_overflow_flag(csrc[3]), .i_uart0_rx_flag(csrc[4]), .i_uart0_tx_flag(csrc[5]),
        .i_timer2_overflow_flag(csrc[6]), .i_uart1_rx_flag(csrc[7]), .i_uart1_tx_flag(csrc[8]));
    aig_core_entry_model aig_core_entry_model_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_core_irq_req(o_core_irq_req), .i_aux_irq_req(o_aux_irq_req),
        .i_aux_vector(o_aux_vector), .o_entry_addr(entry));

    // 250 MHz clock.
    always #2 i_core_clk = ~i_core_clk;

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask

    // One classic cycle; the request is held until ack is sampled high at an edge.
    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge i_core_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= w;
        i_wb_adr <= {2'b00, a};
        i_wb_dat <= {24'h000000, d};
        i_wb_sel <= s;
        @(posedge i_core_clk);
        while (o_wb_ack !== 1'b1 && n < 40)
        begin
            n++;
            @(posedge i_core_clk);
        end
        rdat = o_wb_dat;
        if (n >= 40)
            n_mismatch++;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'h1);
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 8'h00, 4'h1);
        chk(nm, rdat, e);
    endtask

    // Outputs are registered, so two edges pass before a look between edges.
    task automatic put(input logic [8:0] a, input logic [8:0] c);
        @(posedge i_core_clk);
        aux <= a;
        csrc <= c;
        repeat (2) @(posedge i_core_clk);
        @(negedge i_core_clk);
    endtask

    // Main sequence.
    initial
    begin
        logic [7:0] mk;
        int b;
        repeat (8) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        rd(A_PEND, 0, "index");
        rd(A_CORE, 0, "core mask");
        wr(10'h3FC, 8'hFF);
        rd(10'h3FC, 0, "unmapped");
        wr(A_CORE, 8'h7F);
        put(9'h000, 9'h1FF);
        chk("gated core req", o_core_irq_req, 0);
        rd(A_CORE, 32'h7F, "core mask");
        wr(A_CORE, 8'hBF);
        put(9'h000, 9'h1FF);
        chk("core req", o_core_irq_req, 32'h3F);
        wr(A_CORE, 8'hFF);
        for (int k = 0; k < 9; k++)
        begin
            put(9'h000, 9'h001 << k);
            chk("core req", o_core_irq_req, 32'h1 << cbit[k]);
        end
        bus(1'b1, A_CORE, 8'h00, 4'h0);
        rd(A_CORE, 32'hFF, "core mask");
        // Each auxiliary source alone; gate and group both closed.
        wr(A_CORE, 8'h00);
        wr(A_MASK, 8'hFF);
        for (int j = 0; j < 9; j++)
        begin
            b = (j < 3) ? j : j - 1;
            put(9'h001 << j, 9'h000);
            chk("aux req", o_aux_irq_req, 0);
            rd(A_PEND, b + 1, "index");
            rd(A_FLAG, 32'h1 << b, "flags");
            rd(A_MASK, 32'h1 << b, "aux raw");
        end
        // All sources high; masks knocked out from bit zero upward.
        put(9'h1FF, 9'h000);
        for (int m = 0; m < 9; m++)
        begin
            mk = 8'hFF << m;
            wr(A_MASK, mk);
            put(9'h1FF, 9'h000);
            chk("index", o_aux_pending_index, (m < 8) ? m + 1 : 0);
            rd(A_FLAG, {24'h000000, mk}, "flags");
            rd(A_MASK, 32'hFF, "aux raw");
        end
        // Group enable alone lets the shared request through.
        wr(A_MASK, 8'h04);
        wr(A_EXT, 8'h10);
        put(9'h008, 9'h000);
        chk("aux req", o_aux_irq_req, 1);
        chk("entry", entry, 32'h0033);
        rd(A_EXT, 32'h10, "ext ctrl");
        wr(A_EXT, 8'hEF);
        put(9'h008, 9'h000);
        chk("aux req", o_aux_irq_req, 0);
        print_verdict();
    end

    // The sequence needs a few hundred cycles; this leaves a wide margin.
    initial
    begin
        #100000;
        n_mismatch++;
        print_verdict();
    end
endmodule

bind aig_irq_gate aig_irq_gate_chk aig_irq_gate_chk_inst (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_core_undervolt_or_break(i_core_undervolt_or_break),
    .i_analog_undervolt(i_analog_undervolt), .i_serial_rx(i_serial_rx),
    .i_twowire_status(i_twowire_status), .i_serial_tx(i_serial_tx),
    .i_milli_tick(i_milli_tick), .i_conversion_done(i_conversion_done),
    .i_accumulator(i_accumulator), .i_slow_tick(i_slow_tick),
    .o_aux_irq_req(o_aux_irq_req), .o_aux_vector(o_aux_vector),
    .o_aux_pending_index(o_aux_pending_index));
